/* shared/dbs_pkg.sv */
// shared types and constants for the dynamic bus sizing sequencer
package dbs_pkg;

  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 16;
  localparam int          OPND_W          = 32;
  localparam int          SYNC_STAGES     = 3;
  localparam int          RSP_BUF_DEPTH   = 2;
  // clock period in ns and the shortest acknowledge-terminated cycle
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          MIN_BUS_CLOCKS  = 3;
  // operand sizes as byte counts; the low two bits are the size pins
  localparam logic [2:0]  SIZE_BYTE       = 3'h1;
  localparam logic [2:0]  SIZE_WORD       = 3'h2;
  localparam logic [2:0]  SIZE_LONG       = 3'h4;
  localparam logic [2:0]  CNT_RST         = 3'h0;
  localparam logic [31:0] ADDR_RST        = 32'h0000_0000;
  localparam logic [15:0] DATA_RST        = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_STROBE = 3'h2,
    ST_LATCH  = 3'h3,
    ST_END    = 3'h4,
    ST_PUSH   = 3'h5
  } dbs_state_e;

  typedef struct packed {
    logic        write;
    logic [2:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dbs_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic        bus_error;
  } dbs_rsp_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  size;
    logic        addr_valid_strobe_n;
    logic        data_valid_strobe_n;
    logic        read_not_write;
    logic        upper_lane_write_strobe_n;
    logic        lower_lane_write_strobe_n;
    logic [15:0] data;
    logic        data_oe_n;
  } dbs_pins_s;

  localparam dbs_pins_s PINS_RST = '{
    addr: 32'h0000_0000, size: 2'h0, addr_valid_strobe_n: 1'b1,
    data_valid_strobe_n: 1'b1, read_not_write: 1'b1,
    upper_lane_write_strobe_n: 1'b1, lower_lane_write_strobe_n: 1'b1,
    data: 16'h0000, data_oe_n: 1'b1};

endpackage

/* hw/dbs_rsp_buf.sv */
// two-entry response buffer with valid/ready on both sides
`timescale 1ns/1ps
module dbs_rsp_buf #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign o_in_ready  = (cnt_reg != (PW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem_reg[rd_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = i_in_data;
      wr_next          = ptr_inc(wr_reg);
    end
    if (pop) begin
      rd_next = ptr_inc(rd_reg);
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + (PW+1)'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - (PW+1)'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule

/* hw/dbs_sequencer.sv */
// operand sequencer that splits operands into sized 16-bit bus cycles
`timescale 1ns/1ps
// Summary of operation
// - byte write drives operand on both lanes
// - narrow byte read takes upper lane only
// - even byte write asserts upper strobe only
// - even byte read wide takes upper lane
// - odd byte read wide takes lower lane
// - odd byte write asserts lower strobe only
// - narrow word read: two upper-lane byte cycles
// - aligned wide word read in one cycle
// - aligned wide word write, both strobes
// - narrow long read: four upper-lane bytes
// - long write first drives top two bytes
// - wide long read takes two word cycles
// - wide long write: count-2, address+2, repeat
// - strobes qualify address and write data
// - optional internal acknowledge on slave's behalf
// - at least three clocks, unbounded waits
// - ack pair decode, both means wide
module dbs_sequencer (
  // clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  // operand request
  input  wire logic               i_req_valid,
  output logic                    o_req_ready,
  input  wire dbs_pkg::dbs_req_s  i_req,
  // operand response
  output logic                    o_rsp_valid,
  input  wire logic               i_rsp_ready,
  output dbs_pkg::dbs_rsp_s       o_rsp,
  // internal acknowledge configuration
  input  wire logic               i_auto_ack_en,
  input  wire logic               i_auto_ack_wide,
  // external bus outputs
  output logic [31:0]             o_addr,
  output logic                    o_transfer_size_high,
  output logic                    o_transfer_size_low,
  output logic                    o_byte_select_address_bit,
  output logic                    o_address_valid_strobe_n,
  output logic                    o_data_valid_strobe_n,
  output logic                    o_read_not_write,
  output logic                    o_upper_lane_write_strobe_n,
  output logic                    o_lower_lane_write_strobe_n,
  // data bus, split into in, out and enable
  input  wire logic [15:0]        i_data,
  output logic [15:0]             o_data,
  output logic                    o_data_oe_n,
  // external bus inputs
  input  wire logic               i_port_ack_narrow_n,
  input  wire logic               i_port_ack_wide_n,
  input  wire logic               i_bus_error_input_n,
  input  wire logic               i_halt_n
);

  localparam int SW = 4 + dbs_pkg::DATA_W;
  localparam logic [1:0] AUTO_DLY = 2'(dbs_pkg::SYNC_STAGES - 1);

  // input synchronisers: acks, error, halt and data all come from the pins
  logic [SW-1:0] s1_reg, s2_reg, s3_reg;
  logic [3:0]    filt_reg, filt_next;
  logic          ack_narrow, ack_wide, ack_any, bus_error_input, halt;
  logic [15:0]   din;

  always_comb begin
    filt_next = filt_reg;
    for (int i = 0; i < 4; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        filt_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s1_reg   <= '1;
      s2_reg   <= '1;
      s3_reg   <= '1;
      filt_reg <= 4'hF;
    end else begin
      s1_reg   <= {i_data, i_halt_n, i_bus_error_input_n, i_port_ack_wide_n,
                   i_port_ack_narrow_n};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  // both lines asserted is reserved and decodes as a wide port
  assign ack_narrow = !filt_reg[0] && filt_reg[1];
  assign ack_wide   = !filt_reg[1];
  assign ack_any    = ack_narrow || ack_wide;
  assign bus_error_input       = !filt_reg[2];
  assign halt       = !filt_reg[3];
  // data passes the same three stages so it lines up with the filtered ack
  assign din        = s3_reg[SW-1:4];

  // sequencer state
  dbs_pkg::dbs_state_e state_reg, state_next;
  logic [2:0]          cnt_reg, cnt_next;
  logic [31:0]         addr_reg, addr_next;
  logic [31:0]         op_reg, op_next;
  logic [31:0]         rd_reg, rd_next;
  logic                write_reg, write_next;
  logic                wide_reg, wide_next;
  logic                err_reg, err_next;
  logic [1:0]          dly_reg, dly_next;
  dbs_pkg::dbs_pins_s  pins_reg, pins_next;
  logic                buf_ready;
  dbs_pkg::dbs_rsp_s   buf_in;

  // an ack is honoured from the slave or, when enabled, made here
  function automatic logic [1:0] ack_decode(input logic auto_en, input logic auto_wide,
                                            input logic narrow, input logic wide);
    if (auto_en) begin
      return {auto_wide, !auto_wide};
    end
    return {wide, narrow};
  endfunction

  // pin image for a cycle from its count, address and remaining operand
  function automatic dbs_pkg::dbs_pins_s drive_pins(input dbs_pkg::dbs_state_e st,
                                                    input logic [2:0]  cnt,
                                                    input logic [31:0] addr,
                                                    input logic [31:0] op,
                                                    input logic        wr);
    dbs_pkg::dbs_pins_s p;
    logic               strobe;
    p      = dbs_pkg::PINS_RST;
    strobe = (st == dbs_pkg::ST_STROBE) || (st == dbs_pkg::ST_LATCH);
    if (st != dbs_pkg::ST_IDLE && st != dbs_pkg::ST_PUSH) begin
      p.addr           = addr;
      // the count's low bits are the size code: 4->00, 3->11, 2->10, 1->01
      p.size           = cnt[1:0];
      p.read_not_write = !wr;
      if (wr) begin
        p.data_oe_n = 1'b0;
        // a single byte goes out on both lanes, since the width is unknown
        p.data      = (cnt == dbs_pkg::SIZE_BYTE) ? {op[31:24], op[31:24]}
                                                  : op[31:16];
      end
    end
    // address strobe marks the address; data strobe qualifies write data
    p.addr_valid_strobe_n = !strobe;
    p.data_valid_strobe_n = !strobe;
    if (strobe && wr) begin
      p.upper_lane_write_strobe_n = (cnt == dbs_pkg::SIZE_BYTE) && addr[0];
      p.lower_lane_write_strobe_n = (cnt == dbs_pkg::SIZE_BYTE) && !addr[0];
    end
    return p;
  endfunction

  always_comb begin
    logic [1:0] ack;
    logic       two;
    ack        = ack_decode(i_auto_ack_en, i_auto_ack_wide, ack_narrow, ack_wide);
    two        = 1'b0;
    state_next = state_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    op_next    = op_reg;
    rd_next    = rd_reg;
    write_next = write_reg;
    wide_next  = wide_reg;
    err_next   = err_reg;
    dly_next   = dly_reg;
    case (state_reg)
      dbs_pkg::ST_IDLE: begin
        if (i_req_valid) begin
          write_next = i_req.write;
          cnt_next   = i_req.size;
          addr_next  = i_req.addr;
          // operand left-justified so the next bytes to send are always on top
          op_next    = i_req.wdata << (6'(4 - 32'(i_req.size)) * 6'd8);
          rd_next    = 32'h0000_0000;
          err_next   = 1'b0;
          state_next = dbs_pkg::ST_ADDR;
        end
      end
      dbs_pkg::ST_ADDR: begin
        dly_next   = 2'h0;
        state_next = dbs_pkg::ST_STROBE;
      end
      dbs_pkg::ST_STROBE: begin
        // wait states are added a clock at a time with no limit
        // an internal ack still waits until read data has crossed the synchroniser
        dly_next = (dly_reg == 2'h3) ? dly_reg : dly_reg + 2'h1;
        if (bus_error_input) begin
          state_next = dbs_pkg::ST_END;
          err_next   = !halt;
        end else if (ack != 2'h0 && (!i_auto_ack_en || dly_reg >= AUTO_DLY)) begin
          wide_next  = ack[1];
          state_next = dbs_pkg::ST_LATCH;
        end
      end
      dbs_pkg::ST_LATCH: begin
        // a bus error one clock after the ack still cancels this cycle
        if (bus_error_input) begin
          err_next   = !halt;
        end else begin
          two = wide_reg && (cnt_reg != dbs_pkg::SIZE_BYTE);
          if (!wide_reg) begin
            rd_next = {rd_reg[23:0], din[15:8]};
          end else if (cnt_reg == dbs_pkg::SIZE_BYTE) begin
            rd_next = {rd_reg[23:0], addr_reg[0] ? din[7:0] : din[15:8]};
          end else begin
            rd_next = {rd_reg[15:0], din};
          end
          // count and address move only once a good ack is taken
          if (two) begin
            cnt_next  = cnt_reg - 3'h2;
            addr_next = addr_reg + 32'h0000_0002;
            op_next   = {op_reg[15:0], 16'h0000};
          end else begin
            cnt_next  = cnt_reg - 3'h1;
            addr_next = addr_reg + 32'h0000_0001;
            op_next   = {op_reg[23:0], 8'h00};
          end
        end
        state_next = dbs_pkg::ST_END;
      end
      dbs_pkg::ST_END: begin
        // unless the ack is made here, hold off until the slave lets go, or its ack would end the next cycle
        if (i_auto_ack_en || (!ack_any && !bus_error_input)) begin
          if (err_reg || cnt_reg == dbs_pkg::CNT_RST) begin
            state_next = dbs_pkg::ST_PUSH;
          end else begin
            state_next = dbs_pkg::ST_ADDR;
          end
        end
      end
      dbs_pkg::ST_PUSH: begin
        if (buf_ready) begin
          state_next = dbs_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = dbs_pkg::ST_IDLE;
      end
    endcase
    pins_next = drive_pins(state_next, cnt_next, addr_next, op_next, write_next);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= dbs_pkg::ST_IDLE;
      cnt_reg   <= dbs_pkg::CNT_RST;
      addr_reg  <= dbs_pkg::ADDR_RST;
      op_reg    <= 32'h0000_0000;
      rd_reg    <= 32'h0000_0000;
      write_reg <= 1'b0;
      wide_reg  <= 1'b0;
      err_reg   <= 1'b0;
      dly_reg   <= 2'h0;
      pins_reg  <= dbs_pkg::PINS_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      op_reg    <= op_next;
      rd_reg    <= rd_next;
      write_reg <= write_next;
      wide_reg  <= wide_next;
      err_reg   <= err_next;
      dly_reg   <= dly_next;
      pins_reg  <= pins_next;
    end
  end

  assign o_req_ready = (state_reg == dbs_pkg::ST_IDLE);
  // write results carry no data; reads are right-justified
  assign buf_in      = '{rdata: write_reg ? 32'h0000_0000 : rd_reg, bus_error: err_reg};

  // the buffer keeps finished operands while the receiver stalls
  dbs_rsp_buf #(
    .WIDTH ($bits(dbs_pkg::dbs_rsp_s)),
    .DEPTH (dbs_pkg::RSP_BUF_DEPTH)
  ) u_rsp_buf (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (state_reg == dbs_pkg::ST_PUSH),
    .o_in_ready  (buf_ready),
    .i_in_data   (buf_in),
    .o_out_valid (o_rsp_valid),
    .i_out_ready (i_rsp_ready),
    .o_out_data  (o_rsp)
  );

  assign o_addr                      = pins_reg.addr;
  assign o_transfer_size_high        = pins_reg.size[1];
  assign o_transfer_size_low         = pins_reg.size[0];
  assign o_byte_select_address_bit   = pins_reg.addr[0];
  assign o_address_valid_strobe_n    = pins_reg.addr_valid_strobe_n;
  assign o_data_valid_strobe_n       = pins_reg.data_valid_strobe_n;
  assign o_read_not_write            = pins_reg.read_not_write;
  assign o_upper_lane_write_strobe_n = pins_reg.upper_lane_write_strobe_n;
  assign o_lower_lane_write_strobe_n = pins_reg.lower_lane_write_strobe_n;
  assign o_data                      = pins_reg.data;
  assign o_data_oe_n                 = pins_reg.data_oe_n;

endmodule

/* bench/dbs_slave_model.sv */
// behavioural memory slave on the sized 16-bit bus
`timescale 1ns/1ps
module dbs_slave_model (
  // clock
  input  wire logic        i_clock,
  // bus from the sequencer, data already resolved
  input  wire logic [31:0] i_addr,
  input  wire logic        i_as_n,
  input  wire logic        i_ds_n,
  input  wire logic        i_rnw,
  input  wire logic        i_uwe_n,
  input  wire logic        i_lwe_n,
  input  wire logic [15:0] i_wdata,
  // behaviour: port width, ack delay, fault (1 abort, 2 retry, 3 silent)
  input  wire logic        i_wide,
  input  wire logic [3:0]  i_wait,
  input  wire logic [1:0]  i_fault,
  // answers
  output logic [15:0]      o_rdata,
  output logic             o_ack_narrow_n,
  output logic             o_ack_wide_n,
  output logic             o_bus_error_input_n,
  output logic             o_halt_n
);
  logic [7:0]  mem [16];
  logic [3:0]  cnt = 4'h0;
  logic [15:0] last = 16'h0000;
  logic [3:0]  a;
  logic        go;
  assign a = i_addr[3:0];
  assign go = !i_as_n && cnt >= i_wait;
  assign o_ack_narrow_n = !(go && i_fault == 2'h0 && !i_wide);
  assign o_ack_wide_n = !(go && i_fault == 2'h0 && i_wide);
  // bus error stands in place of the ack, so it never trails it late
  assign o_bus_error_input_n = !(go && i_fault inside {2'h1, 2'h2});
  assign o_halt_n = !(go && i_fault == 2'h2);
  // a released bus shows the inverse of its last value, never a held copy
  assign o_rdata = !(i_as_n || !i_rnw) ?
    (i_wide ? {mem[{a[3:1], 1'h0}], mem[{a[3:1], 1'h1}]} : {mem[a], ~mem[a]}) : ~last;
  initial begin
    for (int i = 0; i < 16; i++)
      mem[i] = 8'h00;
  end
  always @(posedge i_clock) begin
    cnt <= i_as_n ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
    last <= o_rdata;
    if (!i_as_n && !i_ds_n && !i_rnw && i_fault == 2'h0) begin
      if (!i_wide)
        mem[a] <= i_wdata[15:8];
      if (i_wide && !i_uwe_n)
        mem[{a[3:1], 1'h0}] <= i_wdata[15:8];
      if (i_wide && !i_lwe_n)
        mem[{a[3:1], 1'h1}] <= i_wdata[7:0];
    end
  end
endmodule

/* bench/dbs_sequencer_properties.sv */
// bus pin assertions for the operand sequencer
`timescale 1ns/1ps
module dbs_sequencer_properties (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        o_req_ready,
  input wire logic        o_rsp_valid,
  input wire logic        i_rsp_ready,
  input wire logic        i_auto_ack_en,
  input wire logic [31:0] o_addr,
  input wire logic        o_transfer_size_high,
  input wire logic        o_transfer_size_low,
  input wire logic        o_byte_select_address_bit,
  input wire logic        o_address_valid_strobe_n,
  input wire logic        o_read_not_write,
  input wire logic        o_upper_lane_write_strobe_n,
  input wire logic        o_lower_lane_write_strobe_n,
  input wire logic [15:0] o_data,
  input wire logic        o_data_oe_n,
  input wire logic        i_port_ack_narrow_n,
  input wire logic        i_port_ack_wide_n,
  input wire logic        i_bus_error_input_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [1:0] sz;
  logic       act;
  logic       wr;
  logic       idle;
  assign sz = {o_transfer_size_high, o_transfer_size_low};
  assign act = !o_address_valid_strobe_n;
  assign wr = act && !o_read_not_write;
  assign idle = i_port_ack_narrow_n && i_port_ack_wide_n && i_bus_error_input_n;
  a_byte_both_lanes: assert property (wr && sz == 2'h1 |-> o_data[15:8] == o_data[7:0])
    else $error("byte write lanes differ");
  a_even_byte_upper: assert property (
    wr && sz == 2'h1 && !o_addr[0] |-> !o_upper_lane_write_strobe_n && o_lower_lane_write_strobe_n)
    else $error("even byte strobe wrong");
  a_odd_byte_lower: assert property (
    wr && sz == 2'h1 && o_addr[0] |-> o_upper_lane_write_strobe_n && !o_lower_lane_write_strobe_n)
    else $error("odd byte strobe wrong");
  a_multi_both_strobes: assert property (
    wr && sz != 2'h1 |-> !o_upper_lane_write_strobe_n && !o_lower_lane_write_strobe_n)
    else $error("word strobes wrong");
  a_select_bit_match: assert property (o_byte_select_address_bit == o_addr[0])
    else $error("select bit differs from address");
  a_cycle_min_len: assert property ($fell(o_address_valid_strobe_n) |-> act [*2])
    else $error("cycle too short");
  a_wait_for_ack: assert property (
    (!i_auto_ack_en && idle) [*5] ##0 act |=> act)
    else $error("cycle ended without ack");
  a_ack_ends_cycle: assert property (
    act && !(i_port_ack_narrow_n && i_port_ack_wide_n) |-> ##[1:8] !act)
    else $error("ack did not end cycle");
  a_fields_hold: assert property (act && $past(act) |->
    $stable(o_addr) && $stable(sz) && (o_read_not_write || $stable(o_data)))
    else $error("address or data moved");
  a_drive_on_write: assert property (act |-> o_data_oe_n == o_read_not_write)
    else $error("data enable wrong");
  a_busy_refuses: assert property (act |-> !o_req_ready)
    else $error("ready during bus cycle");
  a_size_addr_pair: assert property (act && sz != 2'h1 |-> o_addr[0] == (sz == 2'h3))
    else $error("size and address bit mismatch");
  c_narrow: cover property (act && !i_port_ack_narrow_n);
  c_wide: cover property (act && !i_port_ack_wide_n);
  c_bus_error_input: cover property (act && !i_bus_error_input_n);
  c_stall: cover property (o_rsp_valid && !i_rsp_ready && o_req_ready);
endmodule
bind dbs_sequencer dbs_sequencer_properties i_dbs_sequencer_properties (
  .i_clock, .i_rst, .o_req_ready, .o_rsp_valid, .i_rsp_ready, .i_auto_ack_en, .o_addr,
  .o_transfer_size_high, .o_transfer_size_low, .o_byte_select_address_bit,
  .o_address_valid_strobe_n, .o_read_not_write, .o_upper_lane_write_strobe_n,
  .o_lower_lane_write_strobe_n, .o_data, .o_data_oe_n, .i_port_ack_narrow_n,
  .i_port_ack_wide_n, .i_bus_error_input_n);

/* bench/dbs_sequencer_bench.sv */
// self-checking bench for the operand sequencer
`timescale 1ns/1ps
module dbs_sequencer_bench;
  typedef struct {logic w; logic [2:0] s; logic [31:0] a, d; logic wd; logic [31:0] e;} dbs_row_s;
  localparam logic [2:0] SB = dbs_pkg::SIZE_BYTE;
  localparam logic [2:0] SW = dbs_pkg::SIZE_WORD;
  localparam logic [2:0] SL = dbs_pkg::SIZE_LONG;
  dbs_row_s rows [15] = '{
    '{1'h1, SL, 32'h0, 32'h11223344, 1'h1, 32'h0},
    '{1'h0, SL, 32'h0, 32'h0, 1'h1, 32'h11223344},
    '{1'h1, SB, 32'h1, 32'hAA, 1'h1, 32'h0},
    '{1'h0, SW, 32'h0, 32'h0, 1'h1, 32'h11AA},
    '{1'h1, SB, 32'h2, 32'hBB, 1'h1, 32'h0},
    '{1'h0, SL, 32'h0, 32'h0, 1'h0, 32'h11AABB44},
    '{1'h1, SL, 32'h4, 32'h55667788, 1'h0, 32'h0},
    '{1'h0, SL, 32'h4, 32'h0, 1'h1, 32'h55667788},
    '{1'h1, SW, 32'h8, 32'h99CC, 1'h0, 32'h0},
    '{1'h0, SW, 32'h8, 32'h0, 1'h1, 32'h99CC},
    '{1'h0, SB, 32'h9, 32'h0, 1'h0, 32'hCC},
    '{1'h0, SB, 32'h9, 32'h0, 1'h1, 32'hCC},
    '{1'h0, SB, 32'h8, 32'h0, 1'h1, 32'h99},
    '{1'h1, SB, 32'hB, 32'hEE, 1'h0, 32'h0},
    '{1'h0, SW, 32'hA, 32'h0, 1'h0, 32'hEE}};
  logic i_clock = 1'h0, i_rst = 1'h1, i_req_valid = 1'h0, i_rsp_ready = 1'h1;
  logic i_auto_ack_en = 1'h0, i_auto_ack_wide = 1'h0, wide = 1'h1;
  logic o_req_ready, o_rsp_valid, o_transfer_size_high, o_transfer_size_low;
  logic o_byte_select_address_bit, o_address_valid_strobe_n, o_data_valid_strobe_n;
  logic o_read_not_write, o_upper_lane_write_strobe_n, o_lower_lane_write_strobe_n;
  logic o_data_oe_n, i_port_ack_narrow_n, i_port_ack_wide_n, i_bus_error_input_n, i_halt_n;
  logic [31:0] o_addr;
  logic [15:0] i_data, o_data, slave_d;
  logic [3:0] wait_clks = 4'h0;
  logic [1:0] fault = 2'h0;
  dbs_pkg::dbs_req_s i_req = '0;
  dbs_pkg::dbs_rsp_s o_rsp;
  int err_total = 0;
  int compares = 0;
  // the shared data wire: whoever has the enable owns it
  assign i_data = o_data_oe_n ? slave_d : o_data;
  always #5 i_clock = ~i_clock;
  dbs_sequencer i_dbs_sequencer (
    .i_clock, .i_rst, .i_req_valid, .o_req_ready, .i_req, .o_rsp_valid, .i_rsp_ready, .o_rsp,
    .i_auto_ack_en, .i_auto_ack_wide, .o_addr, .o_transfer_size_high, .o_transfer_size_low,
    .o_byte_select_address_bit, .o_address_valid_strobe_n, .o_data_valid_strobe_n,
    .o_read_not_write, .o_upper_lane_write_strobe_n, .o_lower_lane_write_strobe_n, .i_data,
    .o_data, .o_data_oe_n, .i_port_ack_narrow_n, .i_port_ack_wide_n, .i_bus_error_input_n,
    .i_halt_n);
  dbs_slave_model i_dbs_slave_model (
    .i_clock, .i_addr(o_addr), .i_as_n(o_address_valid_strobe_n),
    .i_ds_n(o_data_valid_strobe_n), .i_rnw(o_read_not_write),
    .i_uwe_n(o_upper_lane_write_strobe_n), .i_lwe_n(o_lower_lane_write_strobe_n),
    .i_wdata(i_data), .i_wide(wide), .i_wait(wait_clks), .i_fault(fault), .o_rdata(slave_d),
    .o_ack_narrow_n(i_port_ack_narrow_n), .o_ack_wide_n(i_port_ack_wide_n),
    .o_bus_error_input_n(i_bus_error_input_n), .o_halt_n(i_halt_n));
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      $display("MISMATCH %s expected %b seen %b", n, e, g);
      err_total++;
    end
  endtask
  task automatic send(input logic w, input logic [2:0] s, input logic [31:0] a, d);
    @(posedge i_clock);
    i_req_valid <= 1'h1;
    i_req <= '{write: w, size: s, addr: a, wdata: d};
    @(negedge i_clock);
    while (o_req_ready !== 1'h1) @(negedge i_clock);
    @(posedge i_clock);
    i_req_valid <= 1'h0;
  endtask
  task automatic take(input logic [31:0] e, input logic be);
    @(negedge i_clock);
    while (o_rsp_valid !== 1'h1) @(negedge i_clock);
    chk32("rdata", e, o_rsp.rdata);
    chk1("bus_error", be, o_rsp.bus_error);
    @(posedge i_clock);
  endtask
  task automatic end_sim;
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst <= 1'h0;
    foreach (rows[i]) begin
      wide <= rows[i].wd;
      wait_clks <= i[0] ? 4'h5 : 4'h0;
      send(rows[i].w, rows[i].s, rows[i].a, rows[i].d);
      take(rows[i].e, 1'h0);
    end
    wide <= 1'h0;
    fault <= 2'h1;
    send(1'h0, SL, 32'h4, 32'h0);
    take(32'h0, 1'h1);
    wide <= 1'h1;
    fault <= 2'h2;
    send(1'h1, SW, 32'hC, 32'h1234);
    while (o_address_valid_strobe_n !== 1'h0) @(negedge i_clock);
    while (o_address_valid_strobe_n !== 1'h1) @(negedge i_clock);
    @(posedge i_clock);
    fault <= 2'h0;
    take(32'h0, 1'h0);
    send(1'h0, SW, 32'hC, 32'h0);
    take(32'h1234, 1'h0);
    fault <= 2'h3;
    i_auto_ack_en <= 1'h1;
    i_auto_ack_wide <= 1'h1;
    send(1'h0, SW, 32'h4, 32'h0);
    take(32'h5566, 1'h0);
    wide <= 1'h0;
    i_auto_ack_wide <= 1'h0;
    send(1'h0, SW, 32'h8, 32'h0);
    take(32'h99CC, 1'h0);
    fault <= 2'h0;
    i_auto_ack_en <= 1'h0;
    wide <= 1'h1;
    i_rsp_ready <= 1'h0;
    send(1'h0, SB, 32'h0, 32'h0);
    send(1'h0, SB, 32'h1, 32'h0);
    send(1'h0, SB, 32'h2, 32'h0);
    repeat (40) @(posedge i_clock);
    chk1("req_ready", 1'h0, o_req_ready);
    i_rsp_ready <= 1'h1;
    take(32'h11, 1'h0);
    take(32'hAA, 1'h0);
    take(32'hBB, 1'h0);
    // reset lands in the middle of a slow narrow long read
    wide <= 1'h0;
    wait_clks <= 4'h5;
    send(1'h0, SL, 32'h0, 32'h0);
    repeat (6) @(posedge i_clock);
    i_rst <= 1'h1;
    repeat (2) @(posedge i_clock);
    chk1("as_n", 1'h1, o_address_valid_strobe_n);
    chk1("ds_n", 1'h1, o_data_valid_strobe_n);
    chk1("uwe_n", 1'h1, o_upper_lane_write_strobe_n);
    chk1("lwe_n", 1'h1, o_lower_lane_write_strobe_n);
    chk1("oe_n", 1'h1, o_data_oe_n);
    chk1("rsp_valid", 1'h0, o_rsp_valid);
    i_rst <= 1'h0;
    wide <= 1'h1;
    send(1'h0, SB, 32'h0, 32'h0);
    take(32'h11, 1'h0);
    end_sim();
  end
endmodule
